// ### sim/asr_ctrl_chk.sv
// Checker for the memory pin timing of the controller.
`timescale 1ns/1ps
module asr_chk
	import asr_pkg::*;
(
	input wire logic		clk_sys,
	input wire logic		sys_rst,
	input wire logic		rsp_valid,
	input wire logic [14:0]	word_address,
	input wire logic		chip_sel_n,
	input wire logic		out_en_n,
	input wire logic		wr_en_n,
	input wire logic [7:0]	shared_data_bus_o,
	input wire logic		shared_data_bus_oe
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Pins settle before a write starts and hold through its end, so either grade is met.
	chk_we_read: assert property (!out_en_n |-> wr_en_n) else $error("we low in read");
	chk_no_clash: assert property (!out_en_n |-> !shared_data_bus_oe) else $error("bus clash");
	chk_oe_write: assert property (!wr_en_n |-> out_en_n) else $error("oe low in write");
	chk_addr_held: assert property (!chip_sel_n && !$past(chip_sel_n) |-> $stable(word_address))
		else $error("addr moved");
	chk_wr_setup: assert property ($fell(wr_en_n) |-> !chip_sel_n && shared_data_bus_oe
		&& $stable(shared_data_bus_o) && $stable(word_address)) else $error("write setup");
	chk_we_pulse: assert property ($fell(wr_en_n) |=> $rose(wr_en_n) && !chip_sel_n)
		else $error("write pulse");
	chk_wr_end: assert property ($rose(wr_en_n) |-> shared_data_bus_oe && $stable(shared_data_bus_o))
		else $error("write end");
	chk_rd_answer: assert property ($fell(out_en_n) |-> ##[1:5] rsp_valid) else $error("no answer");
endmodule

bind asr_ctrl asr_chk u_chk (
	.clk_sys            (clk_sys),
	.sys_rst            (sys_rst),
	.rsp_valid          (rsp_valid),
	.word_address       (word_address),
	.chip_sel_n         (chip_sel_n),
	.out_en_n           (out_en_n),
	.wr_en_n            (wr_en_n),
	.shared_data_bus_o  (shared_data_bus_o),
	.shared_data_bus_oe (shared_data_bus_oe)
);

// ### sim/asr_ctrl_tb_top.sv
// Testbench for the static memory controller.
`timescale 1ns/1ps
module asr_ctrl_tb_top;
	import asr_pkg::*;
	logic		clk_sys = 1'h0, sys_rst = 1'h1, req_valid = 1'h0, req_write = 1'h0;
	logic [14:0]	req_addr = 15'h0, word_address;
	logic [7:0]	req_wdata = 8'h0, rsp_rdata, shared_data_bus_o, mem_q, last = 8'h0;
	logic		req_ready, rsp_valid, chip_sel_n, out_en_n, wr_en_n, shared_data_bus_oe, mem_drv;
	int		fails = 0, num_checks = 0;
	// A floating bus toggles each cycle, so a stale byte never reads back by luck.
	wire [7:0]	shared_data_bus_i = shared_data_bus_oe ? shared_data_bus_o : mem_drv ? mem_q : ~last;
	always @(posedge clk_sys) last <= shared_data_bus_i;
	initial forever #50 clk_sys = ~clk_sys;
	asr_ctrl u_dut (
		.clk_sys            (clk_sys),
		.sys_rst            (sys_rst),
		.req_valid          (req_valid),
		.req_write          (req_write),
		.req_addr           (req_addr),
		.req_wdata          (req_wdata),
		.req_ready          (req_ready),
		.rsp_valid          (rsp_valid),
		.rsp_rdata          (rsp_rdata),
		.word_address       (word_address),
		.chip_sel_n         (chip_sel_n),
		.out_en_n           (out_en_n),
		.wr_en_n            (wr_en_n),
		.shared_data_bus_o  (shared_data_bus_o),
		.shared_data_bus_oe (shared_data_bus_oe),
		.shared_data_bus_i  (shared_data_bus_i)
	);
	asr_sram_model #(.T_ACC_NS(T_ACCESS_NS)) u_mem (
		.word_address      (word_address),
		.chip_sel_n        (chip_sel_n),
		.out_en_n          (out_en_n),
		.wr_en_n           (wr_en_n),
		.shared_data_bus_i (shared_data_bus_i),
		.mem_q             (mem_q),
		.mem_drv           (mem_drv)
	);
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Offers one request when idle; a read is judged against the expected byte.
	task automatic req(input logic w, input logic [14:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		repeat (20) if (req_ready !== 1'h1) @(negedge clk_sys);
		{req_valid, req_write, req_addr, req_wdata} = {1'h1, w, a, d};
		@(negedge clk_sys);
		req_valid = 1'h0;
		repeat (20) if (!w && rsp_valid !== 1'h1) @(negedge clk_sys);
		if (!w) chk(rsp_rdata, d);
	endtask
	// The end words and inverse patterns land apart.
	task automatic t_corners();
		req(1'h1, 15'h0000, 8'hA5);
		req(1'h1, 15'h7FFF, 8'h5A);
		req(1'h0, 15'h0000, 8'hA5);
		req(1'h0, 15'h7FFF, 8'h5A);
	endtask
	// Back-to-back writes keep only the last; a later write to the neighbour leaves the word alone.
	task automatic t_overwrite();
		req(1'h1, 15'h0100, 8'h11);
		req(1'h1, 15'h0100, 8'hEE);
		req(1'h1, 15'h0101, 8'h77);
		req(1'h0, 15'h0100, 8'hEE);
		req(1'h0, 15'h0101, 8'h77);
	endtask
	// A reset at the tail of a read parks the pins; the memory keeps its word.
	task automatic t_reset();
		req(1'h1, 15'h1234, 8'h3C);
		req(1'h0, 15'h1234, 8'h3C);
		sys_rst = 1'h1;
		@(negedge clk_sys);
		chk({4'h0, chip_sel_n, out_en_n, wr_en_n, shared_data_bus_oe}, 8'h0E);
		sys_rst = 1'h0;
		req(1'h0, 15'h1234, 8'h3C);
	endtask
	task automatic report_and_stop();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		sys_rst = 1'h0;
		t_corners();
		t_overwrite();
		t_reset();
		report_and_stop();
	end
	// About 80 cycles are needed; 10000 leaves ample margin before a hang is called.
	initial begin
		#1000000;
		fails++;
		report_and_stop();
	end
endmodule

// ### sim/asr_sram_model.sv
// Behavioural model of the static memory behind the controller pins.
`timescale 1ns/1ps
module asr_sram_model
	import asr_pkg::*;
#(
	parameter int T_ACC_NS = 45
)(
	input wire logic [14:0]	word_address,
	input wire logic		chip_sel_n,
	input wire logic		out_en_n,
	input wire logic		wr_en_n,
	input wire logic [7:0]	shared_data_bus_i,
	output logic [7:0]		mem_q,
	output logic			mem_drv
);
	logic [7:0]	mem_arr [32768];
	// The word follows the bus during the overlap, so the value at its end stays.
	always @(chip_sel_n, wr_en_n, word_address, shared_data_bus_i) begin
		if (!chip_sel_n && !wr_en_n) begin
			mem_arr[word_address] = shared_data_bus_i;
		end
	end
	// Pins float at once; data lags the address by the access time, as a slow part would.
	assign mem_drv = !chip_sel_n && !out_en_n && wr_en_n;
	assign #(T_ACC_NS) mem_q = mem_arr[word_address];
endmodule

// ### src/asr_ctrl.sv
// Host controller driving a 32K by 8 asynchronous static memory.
// Function
// RULE1: 32768 bytes, 15-bit address, shared bus.
// RULE2: Memory needs no clock or refresh.
// RULE3: Chip select high means standby, Hi-Z.
// RULE4: Write enable low writes, high reads.
// RULE5: Select without enables means no access.
// RULE6: Write enable stays high during reads.
// RULE7: Selected output follows address changes.
// RULE8: Read data valid within access time.
// RULE9: Address valid before chip select falls; the code drives the address on the same edge as chip select.
// RULE10: Write is select and enable overlap.
// RULE11: Signals valid first; either edge ends.
// RULE12: Data timing refers to ending edge.
// RULE13: Data valid 20 ns before write end.
// RULE14: Data stable through the ending edge.
// RULE15: Address valid 25 ns before write end.
// RULE16: Address may change at write end.
// RULE17: Memory outputs float after enable falls.
// RULE18: Memory may drive after enable rises.
// RULE19: Output enable high keeps bus Hi-Z.
`timescale 1ns/1ps
module asr_ctrl
	import asr_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              req_valid,
	input  wire logic              req_write,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	output logic                   req_ready,
	output logic                   rsp_valid,
	output logic      [DATA_W-1:0] rsp_rdata,
	output logic      [ADDR_W-1:0] word_address,
	output logic                   chip_sel_n,
	output logic                   out_en_n,
	output logic                   wr_en_n,
	output logic      [DATA_W-1:0] shared_data_bus_o,
	output logic                   shared_data_bus_oe,
	input  wire logic [DATA_W-1:0] shared_data_bus_i
);
	typedef struct packed {
		asr_state_e        state;
		logic [3:0]        cnt;
		asr_pins_s         pins;
		logic              ready;
		logic              rsp_v;
		logic [DATA_W-1:0] rdata;
	} asr_ctrl_s;

	asr_ctrl_s         st_reg;
	asr_ctrl_s         st_next;
	asr_req_s          req;
	logic [DATA_W-1:0] bus_sync;

	// Read data comes from another timing domain, so it is synchronised first.
	asr_sync u_sync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.d_in    (shared_data_bus_i),
		.d_out   (bus_sync)
	);

	assign req = '{valid: req_valid, write: req_write, addr: req_addr, wdata: req_wdata};

	// Sequencer; each pin phase lasts whole clock periods, far beyond the memory's ns figures.
	always_comb begin
		st_next       = st_reg;
		st_next.rsp_v = 1'b0;
		case (st_reg.state)
			ST_IDLE: begin
				// Deselected with all enables high: standby and a floating bus. [RULE3] [RULE5]
				st_next.pins.chip_sel_n = 1'b1;
				st_next.pins.out_en_n   = 1'b1;
				st_next.pins.wr_en_n    = 1'b1;
				st_next.pins.bus_oe     = 1'b0;
				st_next.ready           = 1'b1;
				if (req.valid && st_reg.ready) begin
					st_next.ready = 1'b0;
					// Address goes out with chip select in the same edge. [RULE9] [RULE1]
					st_next.pins.word_address = req.addr;
					st_next.pins.chip_sel_n   = 1'b0;
					if (req.write) begin
						// Output enable high keeps the memory off the bus while we drive it. [RULE19]
						st_next.pins.bus_out = req.wdata;
						st_next.pins.bus_oe  = 1'b1;
						st_next.state        = ST_WR_SETUP;
					end else begin
						// Write enable stays high for the whole read. [RULE6] [RULE4]
						st_next.pins.out_en_n = 1'b0;
						st_next.cnt           = RD_CNT;
						st_next.state         = ST_RD;
					end
				end
			end
			ST_RD: begin
				// Wait access time plus the synchroniser delay before sampling. [RULE8] [RULE7]
				if (st_reg.cnt != 4'h0) begin
					st_next.cnt = st_reg.cnt - 4'h1;
				end else begin
					st_next.rdata           = bus_sync;
					st_next.rsp_v           = 1'b1;
					st_next.pins.out_en_n   = 1'b1;
					st_next.pins.chip_sel_n = 1'b1;
					st_next.cnt             = HIZ_CNT;
					st_next.state           = ST_TURN;
				end
			end
			ST_WR_SETUP: begin
				// Address and data already valid when the write opens. [RULE11] [RULE10]
				st_next.pins.wr_en_n = 1'b0;
				st_next.cnt          = WR_CNT;
				st_next.state        = ST_WR_PULSE;
			end
			ST_WR_PULSE: begin
				// Pulse covers data and address setup to the ending edge. [RULE13] [RULE15] [RULE12]
				if (st_reg.cnt != 4'h1) begin
					st_next.cnt = st_reg.cnt - 4'h1;
				end else begin
					// Write enable rising ends the write; data and address hold through it. [RULE14] [RULE16]
					st_next.pins.wr_en_n = 1'b1;
					st_next.cnt          = 4'h1;
					st_next.state        = ST_TURN;
				end
			end
			ST_TURN: begin
				// Bus released one cycle after the ending edge, then a float gap. [RULE17] [RULE18]
				st_next.pins.chip_sel_n = 1'b1;
				st_next.pins.bus_oe     = 1'b0;
				if (st_reg.cnt != 4'h0) begin
					st_next.cnt = st_reg.cnt - 4'h1;
				end else begin
					st_next.ready = 1'b1;
					st_next.state = ST_IDLE;
				end
			end
			default: begin
				st_next.state = ST_IDLE;
			end
		endcase
	end

	// The memory keeps data without any clock from us. [RULE2]
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg                 <= '0;
			st_reg.state           <= ST_IDLE;
			st_reg.pins.chip_sel_n <= 1'b1;
			st_reg.pins.out_en_n   <= 1'b1;
			st_reg.pins.wr_en_n    <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign req_ready          = st_reg.ready;
	assign rsp_valid          = st_reg.rsp_v;
	assign rsp_rdata          = st_reg.rdata;
	assign word_address       = st_reg.pins.word_address;
	assign chip_sel_n         = st_reg.pins.chip_sel_n;
	assign out_en_n           = st_reg.pins.out_en_n;
	assign wr_en_n            = st_reg.pins.wr_en_n;
	assign shared_data_bus_o  = st_reg.pins.bus_out;
	assign shared_data_bus_oe = st_reg.pins.bus_oe;
endmodule

// ### src/asr_pkg.sv
// Package with pin timing, state and carrier types for the static memory controller.
package asr_pkg;

	localparam int ADDR_W        = 15;
	localparam int DATA_W        = 8;
	localparam int CLK_PERIOD_NS = 100;
	// Slow grade figures; the fast grade is covered by the same counts.
	localparam int T_ACCESS_NS   = 45;
	localparam int T_DATA_SU_NS  = 20;
	localparam int T_ADDR_SU_NS  = 25;
	localparam int T_WE_PULSE_NS = 25;
	localparam int T_HIZ_NS      = 20;

	// Least times round up to whole cycles, never below one.
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int RD_CYC  = ns_to_cyc(T_ACCESS_NS) + 1;
	localparam int WR_CYC  = ns_to_cyc(T_WE_PULSE_NS > T_ADDR_SU_NS ? T_WE_PULSE_NS : T_ADDR_SU_NS);
	localparam int HIZ_CYC = ns_to_cyc(T_HIZ_NS);
	localparam logic [3:0] RD_CNT  = 4'(RD_CYC);
	localparam logic [3:0] WR_CNT  = 4'(WR_CYC);
	localparam logic [3:0] HIZ_CNT = 4'(HIZ_CYC);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_TURN
	} asr_state_e;

	// Pins toward the memory.
	typedef struct packed {
		logic [ADDR_W-1:0] word_address;
		logic              chip_sel_n;
		logic              out_en_n;
		logic              wr_en_n;
		logic [DATA_W-1:0] bus_out;
		logic              bus_oe;
	} asr_pins_s;

	// User request.
	typedef struct packed {
		logic              valid;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} asr_req_s;

endpackage

// ### src/asr_sync.sv
// Two-stage synchroniser for the data bus read back from the memory.
`timescale 1ns/1ps
module asr_sync
	import asr_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic [DATA_W-1:0] d_in,
	output logic      [DATA_W-1:0] d_out
);
	typedef struct packed {
		logic [DATA_W-1:0] s1;
		logic [DATA_W-1:0] s2;
	} asr_sync_s;

	asr_sync_s st_reg;
	asr_sync_s st_next;

	// The first stage feeds only the second stage.
	always_comb begin
		st_next    = st_reg;
		st_next.s1 = d_in;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign d_out = st_reg.s2;
endmodule
